// ==== design/pcd_clock_ctrl.sv ====
// top of the clock distribution controller: apb registers, loop model, output dividers
// assumes reference and feedback pins are asynchronous to pclk and much slower than it
`timescale 1ns/1ns
`default_nettype none
module pcd_clock_ctrl import pcd_pkg::*; #(
	parameter int LOCK_MAX_CYC_P = LOCK_MAX_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync0_in,
	input wire logic sync1_in,
	input wire logic feedback_in,
	output logic [4:0] main_clk_out,
	output logic main_clk_out_inv,
	output logic double_rate_clk_out,
	output logic half_rate_clk_out,
	output logic clk_oe_n,
	output logic lock_out
);
	logic sync0_s, sync1_s, fb_s, ref_raw, ref_q_ff, ref_rise;
	logic [PER_W-1:0] ref_per, fb_per;
	logic ref_valid, fb_valid;
	logic [CTRL_W-1:0] ctrl_ff;
	logic loop_en, fsel, rst_out_n;
	logic [31:0] prdata_ff, rd_data;
	logic pready_ff, pslverr_ff, setup, wr_en;
	pcd_loop_t state_ff, nxt_state;
	logic [3:0] match_cnt_ff;
	logic lock_ff, in_tol, tmo_ff, tmo_set, ref_seen_ff;
	logic [TMO_W-1:0] lock_wait_ff;
	logic [PER_W-1:0] hp_ff, osc_cnt_ff;
	logic osc_tgl, div_ph_ff, dist_tgl;
	logic started_ff, run, nxt_dbl, dbl_rise, nxt_main, main_rise;
	logic dbl_ff, main_ff, inv_ff, half_ff, oe_n_ff;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	function automatic logic near(input logic [PER_W-1:0] a, input logic [PER_W-1:0] b);
		near = (a > b) ? ((a - b) <= FREQ_TOL) : ((b - a) <= FREQ_TOL);
	endfunction

	pcd_sync u_sync0 (.clk(pclk), .rst_n(presetn), .d(sync0_in), .q(sync0_s));
	pcd_sync u_sync1 (.clk(pclk), .rst_n(presetn), .d(sync1_in), .q(sync1_s));
	pcd_sync u_syncfb (.clk(pclk), .rst_n(presetn), .d(feedback_in), .q(fb_s));

	assign loop_en = ctrl_ff[CTRL_LOOP_BIT];
	assign fsel = ctrl_ff[CTRL_FSEL_BIT];
	assign ref_raw = ctrl_ff[CTRL_RSEL_BIT] ? sync1_s : sync0_s;
	assign ref_rise = ref_raw & ~ref_q_ff;

	pcd_period_meter u_ref_meter (.clk(pclk), .rst_n(presetn), .sig(ref_raw), .period(ref_per), .valid(ref_valid));
	pcd_period_meter u_fb_meter (.clk(pclk), .rst_n(presetn), .sig(fb_s), .period(fb_per), .valid(fb_valid));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q_ff <= 1'b0;
		end else begin
			ref_q_ff <= ref_raw;
		end
	end

	// apb slave, one access cycle, answer prepared in setup
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready_ff & pwrite;

	always_comb begin
		rd_data = 32'h0000_0000;
		if (reg_hit(paddr, CTRL_OFS)) begin
			rd_data[CTRL_W-1:0] = ctrl_ff;
		end else if (reg_hit(paddr, STAT_OFS)) begin
			rd_data[STAT_LOCK_BIT] = lock_ff;
			rd_data[STAT_TMO_BIT] = tmo_ff;
			rd_data[STAT_RUN_BIT] = run;
		end else if (reg_hit(paddr, PER_OFS)) begin
			rd_data = {hp_ff, ref_per};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~(reg_hit(paddr, CTRL_OFS) | reg_hit(paddr, STAT_OFS) | reg_hit(paddr, PER_OFS));
			prdata_ff <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_en && reg_hit(paddr, CTRL_OFS)) begin
			ctrl_ff <= pwdata[CTRL_W-1:0];
		end
	end

	// lock timeout flag, set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_ff <= 1'b0;
		end else if (tmo_set) begin
			tmo_ff <= 1'b1;
		end else if (wr_en && reg_hit(paddr, STAT_OFS) && pwdata[STAT_TMO_BIT]) begin
			tmo_ff <= 1'b0;
		end
	end

	// loop state: compare feedback period against reference period
	assign in_tol = near(fb_per, ref_per);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_TEST: begin
				if (loop_en) nxt_state = ST_ACQ;
			end
			ST_ACQ: begin
				if (!loop_en) nxt_state = ST_TEST;
				else if (match_cnt_ff == LOCK_STABLE) nxt_state = ST_LOCK;
			end
			ST_LOCK: begin
				if (!loop_en) nxt_state = ST_TEST;
				else if (fb_valid && !in_tol) nxt_state = ST_ACQ;
			end
			default: nxt_state = ST_TEST;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_TEST;
			lock_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			lock_ff <= (nxt_state == ST_LOCK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_cnt_ff <= 4'h0;
		end else if (state_ff != ST_ACQ) begin
			match_cnt_ff <= 4'h0;
		end else if (fb_valid) begin
			match_cnt_ff <= in_tol ? match_cnt_ff + 4'h1 : 4'h0;
		end
	end

	// oscillator half period steered toward equal periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hp_ff <= HP_RST;
		end else if (loop_en && fb_valid && !in_tol && ref_per != '0) begin
			if (fb_per > ref_per && hp_ff > HP_MIN) hp_ff <= hp_ff - 16'h0001;
			else if (fb_per < ref_per && hp_ff != PER_MAX) hp_ff <= hp_ff + 16'h0001;
		end
	end

	assign osc_tgl = loop_en & (osc_cnt_ff >= hp_ff - 16'h0001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt_ff <= '0;
			div_ph_ff <= 1'b0;
		end else if (!loop_en) begin
			osc_cnt_ff <= '0;
			div_ph_ff <= 1'b0;
		end else begin
			osc_cnt_ff <= osc_tgl ? '0 : osc_cnt_ff + 16'h0001;
			div_ph_ff <= div_ph_ff ^ osc_tgl;
		end
	end

	assign dist_tgl = osc_tgl & (fsel | div_ph_ff);

	// lock time watchdog
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_seen_ff <= 1'b0;
			lock_wait_ff <= '0;
		end else begin
			ref_seen_ff <= loop_en & (ref_seen_ff | ref_rise);
			if (state_ff != ST_ACQ || !ref_seen_ff) lock_wait_ff <= '0;
			else if (!tmo_set) lock_wait_ff <= lock_wait_ff + 21'h000001;
		end
	end

	assign tmo_set = (lock_wait_ff == TMO_W'(LOCK_MAX_CYC_P));

	// output dividers, cleared at once by the output enable bit
	assign rst_out_n = presetn & ctrl_ff[CTRL_OE_BIT];
	assign run = loop_en | started_ff;
	assign nxt_dbl = loop_en ? (dbl_ff ^ dist_tgl) : ~ref_raw;
	assign dbl_rise = nxt_dbl & ~dbl_ff;
	assign nxt_main = (run & dbl_rise) ? ~main_ff : main_ff;
	assign main_rise = nxt_main & ~main_ff;

	always_ff @(posedge pclk or negedge rst_out_n) begin
		if (!rst_out_n) begin
			started_ff <= 1'b0;
			dbl_ff <= 1'b0;
			main_ff <= 1'b0;
			inv_ff <= 1'b0;
			half_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			started_ff <= started_ff | ref_rise;
			dbl_ff <= nxt_dbl;
			main_ff <= nxt_main;
			inv_ff <= run ? ~nxt_main : 1'b0;
			half_ff <= main_rise ? ~half_ff : half_ff;
			oe_n_ff <= 1'b0;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign main_clk_out = {5{main_ff}};
	assign main_clk_out_inv = inv_ff;
	assign double_rate_clk_out = dbl_ff;
	assign half_rate_clk_out = half_ff;
	assign clk_oe_n = oe_n_ff;
	assign lock_out = lock_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence test_held_s;
		!loop_en && rst_out_n && !started_ff;
	endsequence

	sequence outs_running_s;
		rst_out_n && run ##1 rst_out_n && run;
	endsequence

	sequence div_one_s;
		osc_tgl && fsel && rst_out_n ##1 rst_out_n;
	endsequence

	lock_off_a: assert property (!loop_en |=> !lock_ff ##1 !lock_ff)
		else $error("lock high with loop disabled");
	hiz_out_a: assert property (!ctrl_ff[CTRL_OE_BIT] |-> clk_oe_n)
		else $error("clock outputs driven while disabled");
	hold_low_a: assert property (test_held_s |-> !main_ff && !inv_ff && !half_ff)
		else $error("outputs left reset state before reference pulse");
	dbl_follow_a: assert property (!loop_en && rst_out_n ##1 !loop_en && rst_out_n |-> dbl_ff == !$past(ref_raw))
		else $error("double rate output not inverse of reference");
	inv_phase_a: assert property (outs_running_s |-> inv_ff != main_ff)
		else $error("inverted output in phase with main");
	main_div_a: assert property (outs_running_s |-> (main_ff != $past(main_ff)) == $rose(dbl_ff))
		else $error("main output not divided from double rate");
	half_div_a: assert property (rst_out_n ##1 rst_out_n |-> (half_ff != $past(half_ff)) == $rose(main_ff))
		else $error("half rate output not divided from main");
	div_two_a: assert property (osc_tgl && !fsel && !div_ph_ff && rst_out_n ##1 rst_out_n && loop_en
		|-> dbl_ff == $past(dbl_ff))
		else $error("divide by two passed an oscillator toggle");
	lock_set_a: assert property ($rose(lock_ff) |-> $past(match_cnt_ff) == LOCK_STABLE && $past(loop_en))
		else $error("lock rose without stable match");
	tmo_flag_a: assert property (tmo_set |=> tmo_ff)
		else $error("lock timeout not flagged");
	apb_ready_a: assert property (setup |=> pready_ff ##1 !pready_ff || setup)
		else $error("apb answer not one cycle after setup");
	div_one_a: assert property (div_one_s |-> dbl_ff != $past(dbl_ff))
		else $error("divide by one dropped an oscillator toggle");
	osc_stop_a: assert property (!loop_en |=> osc_cnt_ff == 16'h0000 && !div_ph_ff)
		else $error("oscillator running with loop disabled");
	lock_drop_a: assert property (state_ff == ST_LOCK && loop_en && fb_valid && !in_tol |=> !lock_ff)
		else $error("lock held after out of tolerance period");
	oe_drive_a: assert property (rst_out_n ##1 rst_out_n |-> !clk_oe_n)
		else $error("clock outputs not driven while enabled");
	tmo_clear_a: assert property (tmo_ff && !tmo_set && wr_en && reg_hit(paddr, STAT_OFS)
		&& pwdata[STAT_TMO_BIT] |=> !tmo_ff)
		else $error("lock timeout flag not cleared");
endmodule
`default_nettype wire

// ==== design/pcd_pkg.sv ====
// constants shared by the clock distribution controller
// assumes a single 125 MHz bus clock and an apb master
package pcd_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int LOCK_TIME_NS = 10_000_000;
	// longest time, so rounded down
	localparam int LOCK_MAX_CYC = LOCK_TIME_NS / CLK_PERIOD_NS;
	localparam int TMO_W = 21;
	localparam int PER_W = 16;
	localparam int ADDR_W = 12;

	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] PER_OFS = 12'h008;

	localparam int CTRL_FSEL_BIT = 0;
	localparam int CTRL_LOOP_BIT = 1;
	localparam int CTRL_RSEL_BIT = 2;
	localparam int CTRL_OE_BIT = 3;
	localparam int CTRL_W = 4;
	localparam logic [3:0] CTRL_RST = 4'hb;

	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_TMO_BIT = 1;
	localparam int STAT_RUN_BIT = 2;

	localparam int PER_HP_LSB = 16;

	localparam logic [3:0] LOCK_STABLE = 4'h8;
	localparam logic [15:0] FREQ_TOL = 16'h0001;
	localparam logic [15:0] HP_RST = 16'h0010;
	localparam logic [15:0] HP_MIN = 16'h0001;
	localparam logic [15:0] PER_MAX = 16'hffff;

	typedef enum logic [2:0] {
		ST_TEST = 3'b001,
		ST_ACQ = 3'b010,
		ST_LOCK = 3'b100
	} pcd_loop_t;
endpackage

// ==== design/pcd_sync.sv ====
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pcd_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_ff;
	logic q_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			q_ff <= 1'b0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule
`default_nettype wire

// ==== design/pcd_period_meter.sv ====
// measures clk cycles between rising edges of a synchronised level
// assumes sig is already on the clk domain
`timescale 1ns/1ns
`default_nettype none
module pcd_period_meter import pcd_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sig,
	output logic [PER_W-1:0] period,
	output logic valid
);
	logic sig_q_ff;
	logic [PER_W-1:0] cnt_ff;
	logic [PER_W-1:0] period_ff;
	logic valid_ff;
	logic rise;

	assign rise = sig & ~sig_q_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sig_q_ff <= 1'b0;
		end else begin
			sig_q_ff <= sig;
		end
	end

	// counter saturates so the first period after a stopped clock reads as very slow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			period_ff <= '0;
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= rise;
			if (rise) begin
				period_ff <= cnt_ff;
				cnt_ff <= 16'h0001;
			end else if (cnt_ff != PER_MAX) begin
				cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end

	assign period = period_ff;
	assign valid = valid_ff;
endmodule
`default_nettype wire

// ==== dv/pcd_ref_model.sv ====
// reference clock source and board feedback wiring
// assumes the bench pclk; a stopped reference stands low
`timescale 1ns/1ns
`default_nettype none
module pcd_ref_model (
	input wire logic pclk,
	input wire logic [1:0] run,
	input wire logic [7:0] hp,
	input wire logic [1:0] fb_sel,
	input wire logic main_clk,
	input wire logic dbl_clk,
	input wire logic half_clk,
	output logic sync0_in,
	output logic sync1_in,
	output logic feedback_in
);
	logic [7:0] cnt_ff = 8'h00;
	logic ref_ff = 1'b0;
	always_ff @(posedge pclk) begin
		cnt_ff <= (cnt_ff + 8'h01 >= hp) ? 8'h00 : cnt_ff + 8'h01;
		if (cnt_ff + 8'h01 >= hp) begin
			ref_ff <= |run & ~ref_ff;
		end
	end
	assign sync0_in = run[0] & ref_ff;
	assign sync1_in = run[1] & ref_ff;
	assign feedback_in = (fb_sel == 2'h0) ? main_clk : (fb_sel == 2'h1) ? dbl_clk : half_clk;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench of the clock distribution controller
// assumes the reference model stands for the board
`timescale 1ns/1ns
`default_nettype none
module tb import pcd_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, slv, sync0_in, sync1_in, feedback_in, inv, dbl, half, clk_oe_n, lock_out;
	logic [4:0] main;
	logic [1:0] run = 2'h0;
	logic [1:0] fb_sel = 2'h0;
	logic [7:0] hp = 8'h14;
	int err_total = 0;
	int n_compared = 0;
	int nd, nm, nh, n;
	always #4 pclk = ~pclk;
	pcd_clock_ctrl #(.LOCK_MAX_CYC_P(200)) u_pcd_clock_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sync0_in(sync0_in), .sync1_in(sync1_in), .feedback_in(feedback_in),
		.main_clk_out(main), .main_clk_out_inv(inv), .double_rate_clk_out(dbl), .half_rate_clk_out(half),
		.clk_oe_n(clk_oe_n), .lock_out(lock_out));
	pcd_ref_model u_pcd_ref_model (.pclk(pclk), .run(run), .hp(hp), .fb_sel(fb_sel), .main_clk(main[0]),
		.dbl_clk(dbl), .half_clk(half), .sync0_in(sync0_in), .sync1_in(sync1_in), .feedback_in(feedback_in));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) err_total++;
	endtask
	task automatic count_edges(input int cyc);
		logic pd, pm, ph;
		int bad;
		nd = 0;
		nm = 0;
		nh = 0;
		bad = 0;
		pd = dbl;
		pm = main[0];
		ph = half;
		repeat (cyc) begin
			@(posedge pclk);
			if (dbl && !pd) nd++;
			if (main[0] && !pm) nm++;
			if (half && !ph) nh++;
			if (main !== {5{main[0]}} || (inv !== ~main[0] && !(nm == 0 && inv === 1'b0 && main[0] === 1'b0))) bad++;
			pd = dbl;
			pm = main[0];
			ph = half;
		end
		check("inv phase", bad, 0);
		check("main half of dbl", nm >= nd / 2 - 1 && nm <= nd / 2 + 1, 1);
		check("half rate", nh >= nd / 4 - 1 && nh <= nd / 4 + 1, 1);
	endtask
	task automatic t_reset;
		check("oe after reset", clk_oe_n, 0);
		apb(1'b0, CTRL_OFS, 32'h0);
		check("ctrl reset", rd, 32'hb);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped err", slv, 1'b1);
		check("unmapped rd", rd, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_test;
		apb(1'b1, CTRL_OFS, 32'h1);
		@(posedge pclk);
		check("oe off", {clk_oe_n, dbl, main, inv, half}, 9'h100);
		apb(1'b1, CTRL_OFS, 32'h9);
		repeat (4) @(posedge pclk);
		check("test lock", lock_out, 0);
		check("held reset", {dbl, main[0], inv, half}, 4'h8);
		run <= 2'h1;
		count_edges(1600);
		check("sync0 rate", nd >= 39 && nd <= 41, 1);
		apb(1'b0, PER_OFS, 32'h0);
		check("ref period", rd[15:0], 16'h0028);
		apb(1'b1, CTRL_OFS, 32'h1);
		apb(1'b1, CTRL_OFS, 32'hd);
		repeat (4) @(posedge pclk);
		check("sync1 idle", {dbl, main[0], inv, half}, 4'h8);
		hp <= 8'h64;
		run <= 2'h2;
		count_edges(4000);
		check("sync1 rate", nd >= 19 && nd <= 21, 1);
		$display("test mode done");
	endtask
	task automatic t_lock;
		logic [3:0] cv [2];
		cv = '{4'hb, 4'ha};
		apb(1'b1, CTRL_OFS, 32'h1);
		hp <= 8'h28;
		run <= 2'h1;
		foreach (cv[i]) begin
			apb(1'b1, CTRL_OFS, {28'h0, cv[i]});
			n = 0;
			while (lock_out !== 1'b1 && n < 20000) begin
				@(posedge pclk);
				n++;
			end
			check("lock", lock_out, 1);
			apb(1'b0, STAT_OFS, 32'h0);
			check("stat lock", rd[0], 1);
			check("stat tmo run", rd[2:1], 2'h3);
			apb(1'b1, STAT_OFS, 32'h2);
			apb(1'b0, STAT_OFS, 32'h0);
			check("tmo clear", rd[2:0], 3'h5);
			count_edges(1600);
			check("main 1:1", nm >= 19 && nm <= 21, 1);
			apb(1'b1, CTRL_OFS, 32'h1);
			repeat (4) @(posedge pclk);
			check("lock off", lock_out, 0);
		end
		$display("test lock done");
	endtask
	task automatic t_ratio;
		logic [1:0] fv [2];
		int lo [2];
		fv = '{2'h1, 2'h2};
		lo = '{9, 39};
		foreach (fv[i]) begin
			fb_sel <= fv[i];
			apb(1'b1, CTRL_OFS, 32'hb);
			n = 0;
			while (lock_out !== 1'b1 && n < 20000) begin
				@(posedge pclk);
				n++;
			end
			check("ratio lock", lock_out, 1);
			count_edges(1600);
			check("main ratio", nm >= lo[i] && nm <= lo[i] + 2, 1);
			apb(1'b1, CTRL_OFS, 32'h1);
		end
		$display("test ratio done");
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset();
		t_test();
		t_lock();
		t_ratio();
		print_verdict();
	end
	initial begin
		repeat (80000) @(posedge pclk);
		err_total++;
		print_verdict();
	end
endmodule
`default_nettype wire
